// ==== hdl/dual_timer_pkg.sv ====
// Constants shared by the dual hundredths timer.
package dual_timer_pkg;
  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned TICK_FAST_MS    = 10;
  localparam int unsigned TICK_SLOW_S     = 36;
  localparam int unsigned FAST_CYCLES     = CLK_HZ / 1000 * TICK_FAST_MS;
  localparam int unsigned SLOW_PER_FAST   = TICK_SLOW_S * 1000 / TICK_FAST_MS;
  localparam int unsigned CNT_W           = 16;
  localparam logic [15:0] CNT_MAX         = 16'hffff;
  localparam logic [15:0] CNT_ZERO        = 16'h0000;
  // Register indices.
  localparam logic [3:0] A_T1_MODE        = 4'h0;
  localparam logic [3:0] A_T1_START_COND  = 4'h1;
  localparam logic [3:0] A_T1_START_IN    = 4'h2;
  localparam logic [3:0] A_T1_RESET_COND  = 4'h3;
  localparam logic [3:0] A_T1_RESET_IN    = 4'h4;
  localparam logic [3:0] A_T1_COUNT       = 4'h5;
  localparam logic [3:0] A_T1_LEVEL       = 4'h6;
  localparam logic [3:0] A_T2_MODE        = 4'h8;
  localparam logic [3:0] A_T2_START_COND  = 4'h9;
  localparam logic [3:0] A_T2_START_IN    = 4'ha;
  localparam logic [3:0] A_T2_RESET_COND  = 4'hb;
  localparam logic [3:0] A_T2_RESET_IN    = 4'hc;
  localparam logic [3:0] A_T2_COUNT       = 4'hd;
  localparam logic [3:0] A_T2_LEVEL       = 4'he;
  // Mode field layout.
  localparam int unsigned SRC_LSB         = 0;
  localparam int unsigned DIR_LSB         = 3;
  localparam int unsigned WRAP_BIT        = 5;
  localparam logic [2:0] SRC_10MS         = 3'h0;
  localparam logic [2:0] SRC_36S          = 3'h1;
  localparam logic [2:0] SRC_ANY_EDGE     = 3'h2;
  localparam logic [2:0] SRC_RISE_EDGE    = 3'h3;
  localparam logic [1:0] DIR_UP           = 2'h0;
  localparam logic [1:0] DIR_FWD_UP       = 2'h1;
  localparam logic [1:0] DIR_FWD_DOWN     = 2'h2;
  localparam int unsigned MODE_W          = 6;
  localparam int unsigned SCOND_W         = 4;
  localparam int unsigned RCOND_W         = 5;
  localparam int unsigned IN_W            = 12;
  localparam logic [5:0]  MODE_RST        = 6'h00;
endpackage : dual_timer_pkg

// ==== hdl/dual_hundredths_timer.sv ====
// Two programmable hundredths timers with register port and level compare.
// Overview of operation
// RULE1 - Two independent timers exist, each with its own mode, start and reset selections and count.
// RULE2 - A timer advances only while a selected start condition or start input is active.
// RULE3 - Any active selected reset condition or reset input forces the count to zero.
// RULE4 - Each count is readable through its own count value register.
// RULE5 - A count above its comparison level raises switching condition 37 or 38.
// RULE6 - Source 0 steps the count by one every 10 ms.
// RULE7 - Source 1 steps the count by one every 36 s.
// RULE8 - Source 2 steps the count on every edge of the timer's pulse input.
// RULE9 - Source 3 steps only on rising edges; sources 4 to 7 never step.
// RULE10 - Direction 0 always counts upward.
// RULE11 - Direction 8 counts up forward and down reverse, 16 the opposite, 24 never steps.
// RULE12 - With the overflow bit clear the count saturates at 65535 and 0.
// RULE13 - With the overflow bit set the count wraps between 65535 and 0.
// RULE14 - Reset wins over start when both are active.
// RULE15 - Writing a count register loads the count; a source change keeps the count.
// RULE16 - Counts are 16-bit unsigned hundredths.
//
// The placing of the registers and the plain strobed port were left to the implementer.
module dual_hundredths_timer
  import dual_timer_pkg::*;
#(
  parameter int unsigned FAST_DIV = FAST_CYCLES,
  parameter int unsigned SLOW_DIV = SLOW_PER_FAST
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Register port.
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // Drive state and inputs.
  input  wire logic [SCOND_W-1:0] start_state,
  input  wire logic [RCOND_W-1:0] reset_state,
  input  wire logic [IN_W-1:0]    digital_inputs,
  input  wire logic              rotation_reverse,
  // Switching conditions.
  output logic                   timer1_above_level,
  output logic                   timer2_above_level
);

  typedef struct packed {
    logic [5:0]         mode;
    logic [SCOND_W-1:0] start_cond;
    logic [IN_W-1:0]    start_in;
    logic [RCOND_W-1:0] reset_cond;
    logic [IN_W-1:0]    reset_in;
    // RULE16 16-bit hundredths.
    logic [15:0]        count;
    logic [15:0]        level;
    logic               pulse_prev;
    logic               above;
  } timer_t;

  typedef struct packed {
    timer_t [1:0] tm;
    logic [31:0]  fast_cnt;
    logic [15:0]  slow_cnt;
    logic [15:0]  rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // Field index of a register address inside its timer's slice; the timer bit a[3] is dropped.
  function automatic logic [3:0] reg_field(input logic [3:0] a);
    reg_field = {1'b0, a[2:0]};
  endfunction

  // One-hot selection of a register field inside a timer's index slice.
  typedef enum logic [7:0] {
    FLD_NONE       = 8'h01,
    FLD_MODE       = 8'h02,
    FLD_START_COND = 8'h04,
    FLD_START_IN   = 8'h08,
    FLD_RESET_COND = 8'h10,
    FLD_RESET_IN   = 8'h20,
    FLD_COUNT      = 8'h40,
    FLD_LEVEL      = 8'h80
  } field_t;

  // Address decode shared by the write and read paths; unmapped slots select nothing.
  function automatic field_t decode_field(input logic [3:0] a);
    logic [3:0] f;
    f = reg_field(a);
    if (f == {1'b0, A_T1_MODE[2:0]}) begin
      decode_field = FLD_MODE;
    end else if (f == {1'b0, A_T1_START_COND[2:0]}) begin
      decode_field = FLD_START_COND;
    end else if (f == {1'b0, A_T1_START_IN[2:0]}) begin
      decode_field = FLD_START_IN;
    end else if (f == {1'b0, A_T1_RESET_COND[2:0]}) begin
      decode_field = FLD_RESET_COND;
    end else if (f == {1'b0, A_T1_RESET_IN[2:0]}) begin
      decode_field = FLD_RESET_IN;
    end else if (f == {1'b0, A_T1_COUNT[2:0]}) begin
      decode_field = FLD_COUNT;
    end else if (f == {1'b0, A_T1_LEVEL[2:0]}) begin
      decode_field = FLD_LEVEL;
    end else begin
      decode_field = FLD_NONE;
    end
  endfunction

  // Mode field extraction.
  function automatic logic [2:0] mode_src(input logic [MODE_W-1:0] md);
    mode_src = md[SRC_LSB +: 3];
  endfunction

  function automatic logic [1:0] mode_dir(input logic [MODE_W-1:0] md);
    mode_dir = md[DIR_LSB +: 2];
  endfunction

  // Step event from the selected source; reserved sources never step.
  function automatic logic src_event(input logic [2:0] src, input logic fast,
                                     input logic slow, input logic pin, input logic prev);
    case (src)
      SRC_10MS:      src_event = fast;
      SRC_36S:       src_event = slow;
      SRC_ANY_EDGE:  src_event = pin ^ prev;
      SRC_RISE_EDGE: src_event = pin & ~prev;
      default:       src_event = 1'b0;
    endcase
  endfunction

  // Counting direction for the rotation-following codes.
  function automatic logic dir_down(input logic [1:0] dir, input logic rev);
    if (dir == DIR_FWD_UP) begin
      dir_down = rev;
    end else if (dir == DIR_FWD_DOWN) begin
      dir_down = ~rev;
    end else begin
      dir_down = 1'b0;
    end
  endfunction

  // The reserved direction code never steps, so a stray write cannot run the count away.
  function automatic logic dir_valid(input logic [1:0] dir);
    dir_valid = (dir == DIR_UP) || (dir == DIR_FWD_UP) || (dir == DIR_FWD_DOWN);
  endfunction

  // Any selected start condition or start input runs the timer.
  function automatic logic run_cause(input timer_t tm, input logic [SCOND_W-1:0] cond,
                                     input logic [IN_W-1:0] pins);
    run_cause = (|(tm.start_cond & cond)) | (|(tm.start_in & pins));
  endfunction

  // Any selected reset condition or reset input clears the timer.
  function automatic logic clear_cause(input timer_t tm, input logic [RCOND_W-1:0] cond,
                                       input logic [IN_W-1:0] pins);
    clear_cause = (|(tm.reset_cond & cond)) | (|(tm.reset_in & pins));
  endfunction

  // Strictly greater compare of count against level.
  function automatic logic above_level(input timer_t tm);
    above_level = (tm.count > tm.level);
  endfunction

  // Read mux for one timer; bits above a field's width read as zero.
  function automatic logic [15:0] read_field(input timer_t tm, input field_t fld);
    if (fld == FLD_MODE) begin
      read_field = {10'h000, tm.mode};
    end else if (fld == FLD_START_COND) begin
      read_field = {12'h000, tm.start_cond};
    end else if (fld == FLD_START_IN) begin
      read_field = {4'h0, tm.start_in};
    end else if (fld == FLD_RESET_COND) begin
      read_field = {11'h000, tm.reset_cond};
    end else if (fld == FLD_RESET_IN) begin
      read_field = {4'h0, tm.reset_in};
    end else if (fld == FLD_COUNT) begin
      read_field = tm.count;
    end else if (fld == FLD_LEVEL) begin
      read_field = tm.level;
    end else begin
      read_field = 16'h0000;
    end
  endfunction

  // Write merge for one timer; bits above a field's width are dropped.
  function automatic timer_t write_field(input timer_t tm, input field_t fld,
                                         input logic [15:0] d);
    write_field = tm;
    if (fld == FLD_MODE) begin
      write_field.mode = d[MODE_W-1:0];
    end else if (fld == FLD_START_COND) begin
      write_field.start_cond = d[SCOND_W-1:0];
    end else if (fld == FLD_START_IN) begin
      write_field.start_in = d[IN_W-1:0];
    end else if (fld == FLD_RESET_COND) begin
      write_field.reset_cond = d[RCOND_W-1:0];
    end else if (fld == FLD_RESET_IN) begin
      write_field.reset_in = d[IN_W-1:0];
    end else if (fld == FLD_COUNT) begin
      // RULE15 load count by write.
      write_field.count = d;
    end else if (fld == FLD_LEVEL) begin
      write_field.level = d;
    end
  endfunction

  // One counting step with direction and limit handling.
  function automatic logic [15:0] step(input logic [15:0] c, input logic down,
                                       input logic wrap);
    if (down) begin
      // RULE12 saturate at zero, RULE13 wrap to top.
      if (c == CNT_ZERO) begin
        step = wrap ? CNT_MAX : CNT_ZERO;
      end else begin
        step = c - 16'h0001;
      end
    end else begin
      if (c == CNT_MAX) begin
        step = wrap ? CNT_ZERO : CNT_MAX;
      end else begin
        step = c + 16'h0001;
      end
    end
  endfunction

  logic fast_tick;
  logic slow_tick;
  logic [1:0] pulse_in;

  // The dividers run free from reset, so the first step after a start may come early.
  // RULE6 10 ms base tick.
  assign fast_tick = (st.fast_cnt == 32'(FAST_DIV - 1));
  // RULE7 36 s tick.
  assign slow_tick = fast_tick && (st.slow_cnt == 16'(SLOW_DIV - 1));
  // RULE8 dedicated pulse inputs.
  assign pulse_in  = {digital_inputs[7], digital_inputs[6]};

  always_comb begin
    logic       run;
    logic       clr;
    logic       adv;
    logic       down;
    logic [2:0] src;
    logic [1:0] dir;
    field_t     fld;
    next_st = st;
    run = 1'b0;
    clr = 1'b0;
    adv = 1'b0;
    down = 1'b0;
    src = SRC_10MS;
    dir = DIR_UP;
    fld = FLD_NONE;
    next_st.fast_cnt = fast_tick ? 32'h0 : st.fast_cnt + 32'h1;
    if (fast_tick) begin
      next_st.slow_cnt = slow_tick ? 16'h0 : st.slow_cnt + 16'h1;
    end
    next_st.rdata = 16'h0000;
    // RULE1 two timer instances.
    for (int i = 0; i < 2; i++) begin
      src = mode_src(st.tm[i].mode);
      dir = mode_dir(st.tm[i].mode);
      // RULE2 start causes ored.
      run = run_cause(st.tm[i], start_state, digital_inputs);
      // RULE3 reset causes ored.
      clr = clear_cause(st.tm[i], reset_state, digital_inputs);
      // RULE9 source step event.
      adv = src_event(src, fast_tick, slow_tick, pulse_in[i], st.tm[i].pulse_prev);
      // RULE10 up, RULE11 follow rotation.
      down = dir_down(dir, rotation_reverse);
      adv = adv & dir_valid(dir);
      // The pin is sampled every cycle, so starting a timer never sees a stale edge.
      next_st.tm[i].pulse_prev = pulse_in[i];
      // RULE14 reset has priority.
      if (clr) begin
        next_st.tm[i].count = CNT_ZERO;
      end else if (run && adv) begin
        next_st.tm[i].count = step(st.tm[i].count, down, st.tm[i].mode[WRAP_BIT]);
      end
      // RULE5 compare against level.
      next_st.tm[i].above = above_level(st.tm[i]);
    end
    // Register writes override counting for the addressed field.
    fld = decode_field(reg_addr);
    if (reg_wr) begin
      next_st.tm[reg_addr[3]] = write_field(next_st.tm[reg_addr[3]], fld, reg_wdata);
    end
    if (reg_rd) begin
      // RULE4 count readback.
      next_st.rdata = read_field(st.tm[reg_addr[3]], fld);
    end
  end

  // Everything, read data included, restarts from zero on reset.

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata          = st.rdata;
  assign timer1_above_level = st.tm[0].above;
  assign timer2_above_level = st.tm[1].above;

endmodule // dual_hundredths_timer

// ==== verif/dual_timer_asserts.sv ====
// Port checker for the dual hundredths timer.
module dual_timer_checker
  import dual_timer_pkg::*;
(
  // Clock, reset and register port.
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Switching conditions.
  input wire logic        timer1_above_level,
  input wire logic        timer2_above_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_unm; reg_rd && (reg_addr == 4'h7 || reg_addr == 4'hf) |=> !reg_rdata; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_mode; reg_wr && reg_addr == A_T1_MODE ##1 reg_rd && reg_addr == A_T1_MODE
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h003f); endproperty
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  property p_sin; reg_wr && reg_addr == A_T2_START_IN ##1 reg_rd && reg_addr == A_T2_START_IN
    |=> reg_rdata == ($past(reg_wdata, 2) & 16'h0fff); endproperty
  a_sin: assert property (p_sin) else $error("start input readback wrong");
  property p_lvl; reg_wr && reg_addr == A_T2_LEVEL ##1 reg_rd && reg_addr == A_T2_LEVEL
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level readback wrong");
  property p_f1; reg_wr && reg_addr == A_T1_LEVEL && reg_wdata == CNT_MAX
    |=> ##1 !timer1_above_level; endproperty
  a_f1: assert property (p_f1) else $error("timer1 above top level");
  property p_f2; reg_wr && reg_addr == A_T2_LEVEL && reg_wdata == CNT_MAX
    |=> ##1 !timer2_above_level; endproperty
  a_f2: assert property (p_f2) else $error("timer2 above top level");
  property p_rel; $fell(sys_rst) |-> !timer1_above_level && !timer2_above_level; endproperty
  a_rel: assert property (p_rel) else $error("flag set after reset");
endmodule // dual_timer_checker
bind dual_hundredths_timer dual_timer_checker u_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .timer1_above_level, .timer2_above_level);

// ==== verif/drive_inputs_model.sv ====
// Far-side model that drives the digital input lines.
module drive_inputs_model
  import dual_timer_pkg::*;
(
  // Clock.
  input  wire logic            sys_clk,
  // Input lines, bit 0 held high as run input.
  output logic      [IN_W-1:0] digital_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial digital_inputs = 12'h001;
  task automatic pulse(input int b, input int n);
    repeat (2 * n) begin
      @(posedge sys_clk);
      digital_inputs[b] <= !digital_inputs[b];
      repeat (2) @(posedge sys_clk);
    end
  endtask
endmodule // drive_inputs_model

// ==== verif/dual_hundredths_timer_tb.sv ====
// Self-checking bench for the dual hundredths timer.
module dual_hundredths_timer_tb;
  import dual_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic            sys_clk = 1'b0;
  logic            sys_rst = 1'b1;
  logic            reg_wr = 1'b0, reg_rd = 1'b0, rotation_reverse = 1'b0, t, run, clr;
  logic [3:0]      reg_addr = 4'h0, start_state = 4'h0;
  logic [4:0]      reset_state = 5'h00;
  logic [15:0]     reg_wdata = 16'h0000, reg_rdata, c0, rv, lvl, exp;
  logic [IN_W-1:0] digital_inputs;
  wire  [1:0]      above;
  logic [31:0]     seed = 32'h445237e9, r;
  logic [5:0]      m;
  int              err_count = 0, checks = 0, p, n, lo;
  dual_hundredths_timer #(.FAST_DIV(10), .SLOW_DIV(3)) DUT (.sys_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .start_state, .reset_state, .digital_inputs,
    .rotation_reverse, .timer1_above_level(above[0]), .timer2_above_level(above[1]));
  drive_inputs_model u_partner (.sys_clk, .digital_inputs);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] model(logic [15:0] c, int k, logic [5:0] md, logic rev);
    for (int i = 0; i < k; i++) begin
      if (md[4:3] == 2'h3) return c;
      if (md[4:3] == DIR_UP || ((md[4:3] == DIR_FWD_UP) != rev)) c = (c == CNT_MAX && !md[5]) ? c : c + 16'h0001;
      else c = (c == CNT_ZERO && !md[5]) ? c : c - 16'h0001;
    end
    return c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rv = reg_rdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    rd(a);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial forever #10 sys_clk = ~sys_clk;
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(4'h7);
    chk(rv, 16'h0000);
    for (int k = 0; k < 12; k++) begin
      r = xs();
      t = k[0];
      m = {r[5:2], 1'b1, r[0]};
      run = r[6] | (k < 4);
      clr = r[7] & (k > 3);
      p = 1 + r[9:8];
      c0 = (k < 2) ? CNT_MAX : (k < 4) ? CNT_ZERO : r[31:16];
      lvl = (k == 1 || k == 2) ? CNT_MAX : r[27:12];
      rotation_reverse <= r[10];
      start_state <= r[14:11];
      reset_state <= {r[15:12], 1'b1};
      wr(A_T1_MODE | {t, 3'h0}, {10'h000, m});
      wr(A_T1_START_IN | {t, 3'h0}, {15'h0000, run});
      wr(A_T1_RESET_COND | {t, 3'h0}, 16'h0000);
      wr(A_T1_LEVEL | {t, 3'h0}, lvl);
      wr(A_T1_COUNT | {t, 3'h0}, c0);
      chk(rv, c0);
      wr(A_T1_RESET_COND | {t, 3'h0}, {11'h000, {5{clr}}});
      u_partner.pulse(6 + t, p);
      repeat (3) @(posedge sys_clk);
      n = (m[2:0] == SRC_ANY_EDGE) ? 2 * p : (m[2:0] == SRC_RISE_EDGE) ? p : 0;
      exp = clr ? CNT_ZERO : model(c0, run ? n : 0, m, r[10]);
      rd(A_T1_COUNT | {t, 3'h0});
      chk(rv, exp);
      chk({15'h0000, above[t]}, {15'h0000, exp > lvl});
    end
    for (int s = 0; s < 2; s++) begin
      lo = s ? 3 : 9;
      wr(A_T1_RESET_COND, 16'h0000);
      wr(A_T1_MODE, {13'h0000, s[2:0]});
      wr(A_T1_START_IN, 16'h0001);
      wr(A_T1_COUNT, 16'h0000);
      repeat (90) @(posedge sys_clk);
      wr(A_T1_START_IN, 16'h0000);
      rd(A_T1_COUNT);
      chk({15'h0000, rv >= lo && rv <= lo + 1}, 16'h0001);
    end
    wr(A_T2_RESET_COND, 16'h0000);
    wr(A_T2_START_IN, 16'h0000);
    wr(A_T2_MODE, 16'h0000);
    start_state <= 4'h4;
    wr(A_T2_START_COND, 16'h0004);
    wr(A_T2_COUNT, 16'h0000);
    repeat (50) @(posedge sys_clk);
    wr(A_T2_START_COND, 16'h0000);
    rd(A_T2_COUNT);
    chk({15'h0000, rv >= 5 && rv <= 6}, 16'h0001);
    wr(A_T2_RESET_IN, 16'h0001);
    rd(A_T2_COUNT);
    chk(rv, 16'h0000);
    print_verdict();
  end
endmodule // dual_hundredths_timer_tb
